//--- logic/byte_word_arith_logic_unit.sv
// arithmetic and logic execution unit of an 8-bit core, plus io bit set/clear
// assumes operands come from the register file in the cycle of i_start and
// that io read data answers o_io_raddr combinationally in that same cycle
//
// What this block does
// [RL1] Add with carry writes d+s+C and plain add writes d+s, flags Z C N V H, one cycle.
// [RL2] Pair plus immediate adds a constant to the high:low pair, flags Z C N V S, two cycles.
// [RL3] Constant and register subtract store d-K or d-s, flags Z C N V H, one cycle.
// [RL4] Register subtract with borrow stores d-s-C, flags Z C N V H, one cycle.
// [RL5] Constant subtract with borrow stores d-K-C, flags Z C N V H, one cycle.
// [RL6] Pair minus immediate subtracts a constant from the pair, flags Z C N V S, two cycles.
// [RL7] AND with register or constant writes in one cycle, keeping carry and half-carry.
// [RL8] OR with register or constant writes in one cycle, updating only Z N V S.
// [RL9] Certain peripheral flags clear on a written one and ignore a written zero.
// [RL10] Io bit set/clear reach only 0x00..0x1F and write back the whole byte read.
// [RL11] Z marks an all-zero result, N copies its top bit, H is carry or borrow out of bit 3.
// [RL12] S is N xor V, and V is signed overflow for arithmetic and zero for logic.
`timescale 1ns/1ps
module byte_word_arith_logic_unit #(
  parameter int unsigned W1C_WIDTH = 8,
  parameter logic [5:0]  W1C_ADDR  = bw_alu_pkg::W1C_REG_ADDR
) (
  input  wire logic                 i_clk,
  input  wire logic                 i_rst_n,
  input  wire logic                 i_ce,
  input  wire logic                 i_start,
  input  wire logic [3:0]           i_op,
  input  wire logic [7:0]           i_dst,
  input  wire logic [7:0]           i_src,
  input  wire logic [7:0]           i_pair_hi,
  input  wire logic [7:0]           i_pair_lo,
  input  wire logic [5:0]           i_word_k,
  input  wire logic [5:0]           i_io_addr,
  input  wire logic [2:0]           i_io_bit,
  input  wire logic [7:0]           i_io_rdata,
  input  wire logic [W1C_WIDTH-1:0] i_w1c_set,
  output logic                      o_ready,
  output logic [5:0]                o_io_raddr,
  output logic [7:0]                o_result,
  output logic [7:0]                o_result_hi,
  output logic                      o_wr,
  output logic                      o_wr_pair,
  output logic [5:0]                o_status,
  output logic                      o_io_we,
  output logic [5:0]                o_io_waddr,
  output logic [7:0]                o_io_wdata,
  output logic                      o_refused,
  output logic [W1C_WIDTH-1:0]      o_w1c_flags
);

  // refuse a flag register placed where bit set/clear cannot reach it
  if (W1C_ADDR > bw_alu_pkg::IO_BIT_ADDR_MAX) begin : g_addr_check
    $error("byte_word_arith_logic_unit: W1C_ADDR beyond bit-op io range");
  end

  bw_alu_pkg::state_t state_q, state_d;
  logic [5:0]         flags_q, flags_d;
  logic [7:0]         res_q, res_d;
  logic [7:0]         res_hi_q, res_hi_d;
  logic               wr_q, wr_d;
  logic               wr_pair_q, wr_pair_d;
  logic [7:0]         word_lo_q, word_lo_d;
  logic [7:0]         word_hi_q, word_hi_d;
  logic               word_c_q, word_c_d;
  logic               word_sub_q, word_sub_d;
  logic               io_we_q, io_we_d;
  logic [5:0]         io_waddr_q, io_waddr_d;
  logic [7:0]         io_wdata_q, io_wdata_d;
  logic               refused_q, refused_d;

  bw_alu_pkg::op_t    op;
  logic               take;
  logic               is_sub;
  logic               cin;
  logic [8:0]         sum9;
  logic [4:0]         nib5;
  logic [8:0]         lo9;
  logic [8:0]         hi9;
  logic [15:0]        r16;
  logic [7:0]         io_rd;
  logic [7:0]         bit_mask;
  logic [W1C_WIDTH-1:0] w1c_flags;

  assign op      = bw_alu_pkg::op_t'(i_op);
  assign o_ready = (state_q == bw_alu_pkg::ST_IDLE);
  assign take    = i_ce && i_start && o_ready;

  // byte adder/subtractor shared by all byte arithmetic
  always_comb begin
    is_sub = (op == bw_alu_pkg::OP_DIFF_REGISTERS) || (op == bw_alu_pkg::OP_DIFF_CONSTANT) ||
             (op == bw_alu_pkg::OP_DIFF_REGISTERS_BORROW) ||
             (op == bw_alu_pkg::OP_DIFF_CONSTANT_BORROW);
    cin    = flags_q[bw_alu_pkg::FLAG_C] &&
             ((op == bw_alu_pkg::OP_ADD_CARRY) ||
              (op == bw_alu_pkg::OP_DIFF_REGISTERS_BORROW) ||
              (op == bw_alu_pkg::OP_DIFF_CONSTANT_BORROW)); // [RL1] [RL4] [RL5]
    if (is_sub) begin
      sum9 = {1'b0, i_dst} - {1'b0, i_src} - {8'h00, cin}; // [RL3]
      nib5 = {1'b0, i_dst[3:0]} - {1'b0, i_src[3:0]} - {4'h0, cin};
    end else begin
      sum9 = {1'b0, i_dst} + {1'b0, i_src} + {8'h00, cin};
      nib5 = {1'b0, i_dst[3:0]} + {1'b0, i_src[3:0]} + {4'h0, cin};
    end
  end

  // word halves: low byte in the first cycle, high byte with its carry in the second
  always_comb begin
    if (op == bw_alu_pkg::OP_PAIR_MINUS_IMMEDIATE) begin
      lo9 = {1'b0, i_pair_lo} - {3'b000, i_word_k}; // [RL6]
    end else begin
      lo9 = {1'b0, i_pair_lo} + {3'b000, i_word_k}; // [RL2]
    end
    if (word_sub_q) begin
      hi9 = {1'b0, word_hi_q} - {8'h00, word_c_q};
    end else begin
      hi9 = {1'b0, word_hi_q} + {8'h00, word_c_q};
    end
    r16 = {hi9[7:0], word_lo_q};
  end

  // io read path: the flag bank answers at its own address
  always_comb begin
    io_rd = i_io_rdata;
    if (i_io_addr == W1C_ADDR) begin
      io_rd = '0;
      io_rd[W1C_WIDTH-1:0] = w1c_flags;
    end
    bit_mask = 8'h01 << i_io_bit;
  end

  // next-state and result computation
  always_comb begin
    state_d    = state_q;
    flags_d    = flags_q;
    res_d      = res_q;
    res_hi_d   = res_hi_q;
    wr_d       = 1'b0;
    wr_pair_d  = 1'b0;
    word_lo_d  = word_lo_q;
    word_hi_d  = word_hi_q;
    word_c_d   = word_c_q;
    word_sub_d = word_sub_q;
    io_we_d    = 1'b0;
    io_waddr_d = io_waddr_q;
    io_wdata_d = io_wdata_q;
    refused_d  = 1'b0;
    unique case (state_q)
      bw_alu_pkg::ST_IDLE: begin
        if (take) begin
          unique case (op)
            bw_alu_pkg::OP_ADD, bw_alu_pkg::OP_ADD_CARRY,
            bw_alu_pkg::OP_DIFF_REGISTERS, bw_alu_pkg::OP_DIFF_CONSTANT,
            bw_alu_pkg::OP_DIFF_REGISTERS_BORROW, bw_alu_pkg::OP_DIFF_CONSTANT_BORROW: begin
              res_d = sum9[7:0];
              wr_d  = 1'b1; // [RL1] [RL3] [RL4] [RL5]
              flags_d[bw_alu_pkg::FLAG_C] = sum9[8];
              flags_d[bw_alu_pkg::FLAG_Z] = (sum9[7:0] == 8'h00); // [RL11]
              flags_d[bw_alu_pkg::FLAG_N] = sum9[7];
              flags_d[bw_alu_pkg::FLAG_H] = nib5[4];
              if (is_sub) begin
                flags_d[bw_alu_pkg::FLAG_V] = (i_dst[7] != i_src[7]) && (sum9[7] != i_dst[7]);
              end else begin
                flags_d[bw_alu_pkg::FLAG_V] = (i_dst[7] == i_src[7]) && (sum9[7] != i_dst[7]);
              end
              flags_d[bw_alu_pkg::FLAG_S] = sum9[7] ^ flags_d[bw_alu_pkg::FLAG_V]; // [RL12]
            end
            bw_alu_pkg::OP_AND_REGISTERS, bw_alu_pkg::OP_BITWISE_CONJ_CONST,
            bw_alu_pkg::OP_OR_REGISTERS, bw_alu_pkg::OP_BITWISE_DISJ_CONST: begin
              if ((op == bw_alu_pkg::OP_AND_REGISTERS) ||
                  (op == bw_alu_pkg::OP_BITWISE_CONJ_CONST)) begin
                res_d = i_dst & i_src; // [RL7]
              end else begin
                res_d = i_dst | i_src; // [RL8]
              end
              wr_d = 1'b1;
              flags_d[bw_alu_pkg::FLAG_Z] = (res_d == 8'h00); // [RL11]
              flags_d[bw_alu_pkg::FLAG_N] = res_d[7];
              flags_d[bw_alu_pkg::FLAG_V] = 1'b0; // [RL12]
              flags_d[bw_alu_pkg::FLAG_S] = res_d[7];
            end
            bw_alu_pkg::OP_PAIR_PLUS_IMMEDIATE, bw_alu_pkg::OP_PAIR_MINUS_IMMEDIATE: begin
              word_lo_d  = lo9[7:0];
              word_c_d   = lo9[8];
              word_hi_d  = i_pair_hi;
              word_sub_d = (op == bw_alu_pkg::OP_PAIR_MINUS_IMMEDIATE);
              state_d    = bw_alu_pkg::ST_WORD_HI; // [RL2] [RL6]
            end
            bw_alu_pkg::OP_IO_BIT_SET, bw_alu_pkg::OP_IO_BIT_CLEAR: begin
              if (i_io_addr <= bw_alu_pkg::IO_BIT_ADDR_MAX) begin
                io_we_d    = 1'b1; // [RL10]
                io_waddr_d = i_io_addr;
                if (op == bw_alu_pkg::OP_IO_BIT_SET) begin
                  io_wdata_d = io_rd | bit_mask;
                end else begin
                  io_wdata_d = io_rd & ~bit_mask;
                end
              end else begin
                refused_d = 1'b1; // [RL10]
              end
            end
            default: begin
              refused_d = 1'b1; // unknown opcode
            end
          endcase
        end
      end
      bw_alu_pkg::ST_WORD_HI: begin
        res_d     = r16[7:0];
        res_hi_d  = r16[15:8];
        wr_d      = 1'b1;
        wr_pair_d = 1'b1; // [RL2] [RL6]
        flags_d[bw_alu_pkg::FLAG_Z] = (r16 == 16'h0000); // [RL11]
        flags_d[bw_alu_pkg::FLAG_N] = r16[15];
        if (word_sub_q) begin
          flags_d[bw_alu_pkg::FLAG_V] = word_hi_q[7] && !r16[15];
          flags_d[bw_alu_pkg::FLAG_C] = r16[15] && !word_hi_q[7];
        end else begin
          flags_d[bw_alu_pkg::FLAG_V] = !word_hi_q[7] && r16[15];
          flags_d[bw_alu_pkg::FLAG_C] = !r16[15] && word_hi_q[7];
        end
        flags_d[bw_alu_pkg::FLAG_S] = r16[15] ^ flags_d[bw_alu_pkg::FLAG_V]; // [RL12]
        state_d = bw_alu_pkg::ST_IDLE;
      end
      default: begin
        state_d = bw_alu_pkg::ST_IDLE;
      end
    endcase
  end

  // state registers, frozen while the clock enable is low
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      state_q    <= bw_alu_pkg::ST_IDLE;
      flags_q    <= bw_alu_pkg::STATUS_RESET;
      res_q      <= bw_alu_pkg::BYTE_RESET;
      res_hi_q   <= bw_alu_pkg::BYTE_RESET;
      wr_q       <= 1'b0;
      wr_pair_q  <= 1'b0;
      word_lo_q  <= bw_alu_pkg::BYTE_RESET;
      word_hi_q  <= bw_alu_pkg::BYTE_RESET;
      word_c_q   <= 1'b0;
      word_sub_q <= 1'b0;
      io_we_q    <= 1'b0;
      io_waddr_q <= bw_alu_pkg::IO_RESET;
      io_wdata_q <= bw_alu_pkg::BYTE_RESET;
      refused_q  <= 1'b0;
    end else if (i_ce) begin
      state_q    <= state_d;
      flags_q    <= flags_d;
      res_q      <= res_d;
      res_hi_q   <= res_hi_d;
      wr_q       <= wr_d;
      wr_pair_q  <= wr_pair_d;
      word_lo_q  <= word_lo_d;
      word_hi_q  <= word_hi_d;
      word_c_q   <= word_c_d;
      word_sub_q <= word_sub_d;
      io_we_q    <= io_we_d;
      io_waddr_q <= io_waddr_d;
      io_wdata_q <= io_wdata_d;
      refused_q  <= refused_d;
    end
  end

  // write-back of a whole byte clears every flag that read as set, except the bit a clear op zeroes and any bit hardware sets in the write cycle
  w1c_flag_bank #(
    .WIDTH (W1C_WIDTH)
  ) u_w1c_flags (
    .i_clk   (i_clk),
    .i_rst_n (i_rst_n),
    .i_ce    (i_ce),
    .i_set   (i_w1c_set),
    .i_wr    (io_we_q && (io_waddr_q == W1C_ADDR)), // [RL9] [RL10]
    .i_wdata (io_wdata_q[W1C_WIDTH-1:0]),
    .o_flags (w1c_flags)
  );

  // outputs
  assign o_io_raddr  = i_io_addr;
  assign o_result    = res_q;
  assign o_result_hi = res_hi_q;
  assign o_wr        = wr_q;
  assign o_wr_pair   = wr_pair_q;
  assign o_status    = flags_q;
  assign o_io_we     = io_we_q;
  assign o_io_waddr  = io_waddr_q;
  assign o_io_wdata  = io_wdata_q;
  assign o_refused   = refused_q;
  assign o_w1c_flags = w1c_flags;

endmodule

//--- logic/bw_alu_pkg.sv
// shared constants for the byte/word arithmetic and logic unit
// assumes a single core clock; status flags are held inside the unit
package bw_alu_pkg;

  // operation codes presented on i_op
  typedef enum logic [3:0] {
    OP_ADD                    = 4'h0,
    OP_ADD_CARRY              = 4'h1,
    OP_DIFF_REGISTERS         = 4'h2,
    OP_DIFF_CONSTANT          = 4'h3,
    OP_DIFF_REGISTERS_BORROW  = 4'h4,
    OP_DIFF_CONSTANT_BORROW   = 4'h5,
    OP_AND_REGISTERS          = 4'h6,
    OP_BITWISE_CONJ_CONST     = 4'h7,
    OP_OR_REGISTERS           = 4'h8,
    OP_BITWISE_DISJ_CONST     = 4'h9,
    OP_PAIR_PLUS_IMMEDIATE    = 4'hA,
    OP_PAIR_MINUS_IMMEDIATE   = 4'hB,
    OP_IO_BIT_SET             = 4'hC,
    OP_IO_BIT_CLEAR           = 4'hD
  } op_t;

  // sequencer states
  typedef enum logic [0:0] {
    ST_IDLE    = 1'b0,
    ST_WORD_HI = 1'b1
  } state_t;

  // status flag positions; C to H fill o_status, FLAG_W lies one bit above its six bits
  localparam int unsigned FLAG_C = 0;
  localparam int unsigned FLAG_Z = 1;
  localparam int unsigned FLAG_N = 2;
  localparam int unsigned FLAG_V = 3;
  localparam int unsigned FLAG_S = 4;
  localparam int unsigned FLAG_H = 5;
  localparam int unsigned FLAG_W = 6;

  // reset values
  localparam logic [5:0] STATUS_RESET = 6'h00;
  localparam logic [7:0] BYTE_RESET   = 8'h00;
  localparam logic [5:0] IO_RESET     = 6'h00;

  // io space reachable by single-bit set and clear
  localparam logic [5:0] IO_BIT_ADDR_MIN = 6'h00;
  localparam logic [5:0] IO_BIT_ADDR_MAX = 6'h1F;

  // default location of the write-one-to-clear flag register
  localparam logic [5:0] W1C_REG_ADDR = 6'h0E;

  // cycle counts from acceptance to result write
  localparam int unsigned BYTE_OP_CYCLES = 1;
  localparam int unsigned WORD_OP_CYCLES = 2;

endpackage

//--- logic/w1c_flag_bank.sv
// bank of peripheral status flags that hardware sets and a write of one clears
// assumes the write strobe and data are synchronous to i_clk
`timescale 1ns/1ps
module w1c_flag_bank #(
  parameter int unsigned WIDTH = 8
) (
  input  wire logic             i_clk,
  input  wire logic             i_rst_n,
  input  wire logic             i_ce,
  input  wire logic [WIDTH-1:0] i_set,
  input  wire logic             i_wr,
  input  wire logic [WIDTH-1:0] i_wdata,
  output logic      [WIDTH-1:0] o_flags
);

  logic [WIDTH-1:0] flags_q;
  logic [WIDTH-1:0] flags_d;

  // refuse widths the io byte cannot carry
  if (WIDTH < 1 || WIDTH > 8) begin : g_width_check
    $error("w1c_flag_bank: WIDTH must be 1 to 8");
  end

  // per bit: a one written clears, zero leaves alone, a hardware set wins
  for (genvar b = 0; b < WIDTH; b++) begin : g_bit
    always_comb begin
      flags_d[b] = flags_q[b];
      if (i_wr && i_wdata[b]) begin
        flags_d[b] = 1'b0; // [RL9]
      end
      if (i_set[b]) begin
        flags_d[b] = 1'b1;
      end
    end
  end

  // flag storage
  always_ff @(posedge i_clk) begin
    if (!i_rst_n) begin
      flags_q <= '0;
    end else if (i_ce) begin
      flags_q <= flags_d;
    end
  end

  assign o_flags = flags_q;

endmodule

//--- verif/alu_monitor.sv
// concurrent checks on the ports of the arithmetic and logic unit
// assumes one core clock and a synchronous active-low reset
`timescale 1ns/1ps
module alu_monitor #(
  parameter int unsigned W1C_WIDTH = 8,
  parameter logic [5:0]  W1C_ADDR  = bw_alu_pkg::W1C_REG_ADDR
) (
  input wire logic                 i_clk,
  input wire logic                 i_rst_n,
  input wire logic                 i_ce,
  input wire logic                 i_start,
  input wire logic [3:0]           i_op,
  input wire logic [5:0]           i_io_addr,
  input wire logic [2:0]           i_io_bit,
  input wire logic [W1C_WIDTH-1:0] i_w1c_set,
  input wire logic                 o_ready,
  input wire logic [7:0]           o_result,
  input wire logic [7:0]           o_result_hi,
  input wire logic                 o_wr,
  input wire logic                 o_wr_pair,
  input wire logic [5:0]           o_status,
  input wire logic                 o_io_we,
  input wire logic [5:0]           o_io_waddr,
  input wire logic [7:0]           o_io_wdata,
  input wire logic                 o_refused,
  input wire logic [W1C_WIDTH-1:0] o_w1c_flags
);
  logic                 take;
  logic                 io_op;
  logic [W1C_WIDTH-1:0] wd;
  // accepted request, bit op kind and flag slice of the io write data
  assign take  = i_ce && i_start && o_ready;
  assign io_op = i_op inside {4'hC, 4'hD};
  assign wd    = o_io_wdata[W1C_WIDTH-1:0];
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);
  chk_byte_latency: assert property (take && i_op <= 4'h9 |=> o_wr && !o_wr_pair)
    else $error("byte result not written one cycle after take");
  chk_word_latency: assert property (
    (take && i_op inside {4'hA, 4'hB}) ##1 i_ce |-> !o_ready && !o_wr ##1 o_wr && o_wr_pair)
    else $error("word result not written two cycles after take");
  chk_zero_flag: assert property (o_wr |-> o_status[bw_alu_pkg::FLAG_Z] ==
    (o_wr_pair ? {o_result_hi, o_result} == 16'h0000 : o_result == 8'h00))
    else $error("zero flag does not match result");
  chk_neg_flag: assert property (o_wr |-> o_status[bw_alu_pkg::FLAG_N] ==
    (o_wr_pair ? o_result_hi[7] : o_result[7]))
    else $error("negative flag does not match top bit");
  chk_sign_flag: assert property (o_wr |-> o_status[bw_alu_pkg::FLAG_S] ==
    (o_status[bw_alu_pkg::FLAG_N] ^ o_status[bw_alu_pkg::FLAG_V]))
    else $error("sign flag is not n xor v");
  chk_logic_flags: assert property (take && i_op inside {[4'h6:4'h9]} |=>
    !o_status[bw_alu_pkg::FLAG_V] && $stable(o_status[bw_alu_pkg::FLAG_C])
    && $stable(o_status[bw_alu_pkg::FLAG_H])) else $error("logic op flags wrong");
  chk_io_refuse: assert property (take && io_op && i_io_addr > 6'h1F |=>
    o_refused && !o_io_we) else $error("bit op above io range not refused");
  chk_io_write: assert property (take && io_op && i_io_addr <= 6'h1F |=> o_io_we &&
    o_io_waddr == $past(i_io_addr) && o_io_wdata[$past(i_io_bit)] == ($past(i_op) == 4'hC))
    else $error("bit op write-back wrong");
  chk_w1c_clear: assert property (o_io_we && i_ce && o_io_waddr == W1C_ADDR |=>
    (o_w1c_flags & $past(wd) & ~$past(i_w1c_set)) == '0)
    else $error("flag written as one not cleared");
  // main scenarios reached
  cov_word: cover property (take && i_op == 4'hA);
  cov_refuse: cover property (o_refused);
  cov_w1c: cover property (o_io_we && o_io_waddr == W1C_ADDR);
endmodule
bind byte_word_arith_logic_unit alu_monitor #(.W1C_WIDTH(W1C_WIDTH), .W1C_ADDR(W1C_ADDR)) mon (
  .i_clk, .i_rst_n, .i_ce, .i_start, .i_op, .i_io_addr, .i_io_bit, .i_w1c_set, .o_ready,
  .o_result, .o_result_hi, .o_wr, .o_wr_pair, .o_status, .o_io_we, .o_io_waddr, .o_io_wdata,
  .o_refused, .o_w1c_flags);

//--- verif/io_space_model.sv
// io space behind the unit: byte array read combinationally, written whole
// assumes write strobe and data are synchronous to i_clk
`timescale 1ns/1ps
module io_space_model (
  input  wire logic       i_clk,
  input  wire logic [5:0] i_raddr,
  input  wire logic       i_we,
  input  wire logic [5:0] i_waddr,
  input  wire logic [7:0] i_wdata,
  output logic      [7:0] o_rdata
);
  logic [7:0] mem [64];
  // fixed start pattern per address
  initial for (int a = 0; a < 64; a++) mem[a] = 8'hA0 ^ 8'(a);
  // read answers the address in the same cycle
  assign o_rdata = mem[i_raddr];
  // whole byte stored as written back by a bit op
  always @(posedge i_clk) if (i_we) mem[i_waddr] <= i_wdata;
endmodule

//--- verif/tb.sv
// self-checking bench for the arithmetic and logic unit
// assumes the io space model answers reads in the same cycle
`timescale 1ns/1ps
`define check(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_mismatch++; \
  $display("CHECK FAILED %s expected %h seen %h", nm, e, g); end end
module tb;
  logic       i_clk = 1'b0;
  logic       i_rst_n, i_ce, i_start, o_ready, o_wr, o_wr_pair, o_io_we, o_refused;
  logic [2:0] i_io_bit;
  logic [3:0] i_op;
  logic [5:0] i_word_k, i_io_addr, o_io_raddr, o_status, o_io_waddr;
  logic [7:0] i_dst, i_src, i_pair_hi, i_pair_lo, i_io_rdata, i_w1c_set;
  logic [7:0] o_result, o_result_hi, o_io_wdata, o_w1c_flags;
  int         n_mismatch = 0;
  int         n_compared = 0;
  byte_word_arith_logic_unit dut (.i_clk, .i_rst_n, .i_ce, .i_start, .i_op, .i_dst, .i_src,
    .i_pair_hi, .i_pair_lo, .i_word_k, .i_io_addr, .i_io_bit, .i_io_rdata, .i_w1c_set,
    .o_ready, .o_io_raddr, .o_result, .o_result_hi, .o_wr, .o_wr_pair, .o_status, .o_io_we,
    .o_io_waddr, .o_io_wdata, .o_refused, .o_w1c_flags);
  io_space_model model (.i_clk, .i_raddr(o_io_raddr), .i_we(o_io_we), .i_waddr(o_io_waddr),
    .i_wdata(o_io_wdata), .o_rdata(i_io_rdata));
  // 200 MHz core clock
  always #2.5 i_clk = ~i_clk;
  task automatic results();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  // one request, sampled at the second edge; hold leaves i_start up until the caller drops it
  task automatic go(input logic [3:0] op, input logic [7:0] d, s, input logic [5:0] k,
                    input logic hold);
    @(posedge i_clk);
    i_start <= 1'b1;
    i_op <= op;
    i_dst <= d;
    i_pair_hi <= d;
    i_io_addr <= d[5:0];
    i_src <= s;
    i_pair_lo <= s;
    i_word_k <= k;
    i_io_bit <= k[2:0];
    @(posedge i_clk);
    i_start <= hold;
    #1;
  endtask
  task automatic byte_op(input logic [3:0] op, input logic [7:0] d, s, r, input logic [5:0] st);
    go(op, d, s, 6'h00, 1'b0);
    `check("byte write", 1'b1, o_wr)
    `check("byte result", r, o_result)
    `check("byte status", st, o_status)
  endtask
  task automatic word_op(input logic [3:0] op, input logic [15:0] p, input logic [5:0] k,
                         input logic [15:0] r, input logic [5:0] st);
    go(op, p[15:8], p[7:0], k, 1'b1);
    `check("word busy", 2'b00, {o_ready, o_wr})
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    `check("word write", 2'b11, {o_wr, o_wr_pair})
    `check("word result", r, {o_result_hi, o_result})
    `check("word status", st, o_status)
    @(posedge i_clk);
    #1;
    `check("busy request ignored", 1'b0, o_wr)
  endtask
  task automatic io_op(input logic [3:0] op, input logic [7:0] a, input logic [5:0] b,
                       input logic [1:0] we_ref, input logic [7:0] wd);
    go(op, a, 8'h00, b, 1'b0);
    `check("io write or refuse", we_ref, {o_io_we, o_refused})
    if (we_ref[1]) `check("io write data", wd, o_io_wdata)
  endtask
  task automatic t_arith();
    byte_op(4'h0, 8'h0F, 8'h01, 8'h10, 6'h20);
    byte_op(4'h0, 8'hFF, 8'h01, 8'h00, 6'h23);
    byte_op(4'h1, 8'h10, 8'h20, 8'h31, 6'h00);
    byte_op(4'h0, 8'h7F, 8'h01, 8'h80, 6'h2C);
    byte_op(4'h3, 8'h10, 8'h01, 8'h0F, 6'h20);
    byte_op(4'h2, 8'h00, 8'h01, 8'hFF, 6'h35);
    byte_op(4'h5, 8'h10, 8'h0F, 8'h00, 6'h22);
    byte_op(4'h2, 8'h00, 8'h01, 8'hFF, 6'h35);
    byte_op(4'h4, 8'h05, 8'h02, 8'h02, 6'h00);
    byte_op(4'h2, 8'h80, 8'h01, 8'h7F, 6'h38);
    $display("test arith done");
  endtask
  task automatic t_logic();
    byte_op(4'h2, 8'h00, 8'h01, 8'hFF, 6'h35);
    byte_op(4'h6, 8'hF0, 8'h0F, 8'h00, 6'h23);
    byte_op(4'h7, 8'h81, 8'hFF, 8'h81, 6'h35);
    byte_op(4'h8, 8'h00, 8'h00, 8'h00, 6'h23);
    byte_op(4'h9, 8'h40, 8'h80, 8'hC0, 6'h35);
    $display("test logic done");
  endtask
  task automatic t_word();
    word_op(4'hA, 16'h7FFF, 6'h01, 16'h8000, 6'h2C);
    word_op(4'hB, 16'h0000, 6'h01, 16'hFFFF, 6'h35);
    word_op(4'hB, 16'h0040, 6'h3F, 16'h0001, 6'h20);
    word_op(4'hB, 16'h0001, 6'h01, 16'h0000, 6'h22);
    $display("test word done");
  endtask
  task automatic t_io();
    io_op(4'hC, 8'h05, 6'h01, 2'b10, 8'hA7);
    io_op(4'hD, 8'h05, 6'h00, 2'b10, 8'hA6);
    io_op(4'hD, 8'h1F, 6'h07, 2'b10, 8'h3F);
    io_op(4'hC, 8'h20, 6'h00, 2'b01, 8'h00);
    io_op(4'hE, 8'h00, 6'h00, 2'b01, 8'h00);
    $display("test io done");
  endtask
  task automatic t_w1c();
    @(posedge i_clk);
    i_w1c_set <= 8'h03;
    @(posedge i_clk);
    i_w1c_set <= 8'h00;
    @(posedge i_clk);
    #1;
    `check("flags set", 8'h03, o_w1c_flags)
    io_op(4'hD, 8'h0E, 6'h01, 2'b10, 8'h01);
    @(posedge i_clk);
    #1;
    `check("flag kept on zero", 8'h02, o_w1c_flags)
    io_op(4'hC, 8'h0E, 6'h03, 2'b10, 8'h0A);
    @(posedge i_clk);
    #1;
    `check("flag cleared on one", 8'h00, o_w1c_flags)
    $display("test w1c done");
  endtask
  // enable low freezes state and the flag bank; a hardware set beats a clear
  task automatic t_ce();
    @(posedge i_clk);
    i_ce <= 1'b0;
    i_w1c_set <= 8'h04;
    go(4'h9, 8'h80, 8'h01, 6'h00, 1'b1);
    `check("frozen write and flag", 2'b00, {o_wr, o_w1c_flags[2]})
    @(posedge i_clk);
    i_ce <= 1'b1;
    @(posedge i_clk);
    i_start <= 1'b0;
    #1;
    `check("enabled write", 1'b1, o_wr)
    `check("enabled result", 8'h81, o_result)
    `check("enabled status", 6'h34, o_status)
    `check("flag set while enabled", 8'h04, o_w1c_flags)
    io_op(4'hD, 8'h0E, 6'h00, 2'b10, 8'h04);
    @(posedge i_clk);
    i_w1c_set <= 8'h00;
    #1;
    `check("set wins over clear", 8'h04, o_w1c_flags)
    io_op(4'hC, 8'h0E, 6'h00, 2'b10, 8'h05);
    @(posedge i_clk);
    #1;
    `check("flag cleared after set", 8'h00, o_w1c_flags)
    $display("test ce done");
  endtask
  // watchdog against a hang
  initial begin
    repeat (4000) @(posedge i_clk);
    n_mismatch++;
    results();
  end
  // reset for ten cycles, then the scenarios
  initial begin
    {i_rst_n, i_start, i_op, i_dst, i_src, i_pair_hi, i_pair_lo} = '0;
    {i_word_k, i_io_addr, i_io_bit, i_w1c_set} = '0;
    i_ce = 1'b1;
    repeat (10) @(posedge i_clk);
    i_rst_n <= 1'b1;
    t_arith();
    t_logic();
    t_word();
    t_io();
    t_w1c();
    t_ce();
    results();
  end
endmodule
